// *** chb_regs.sv ***
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Zone codes zero to four report temperature
// - Removal five, disabled six, seven never
// - Bypass field zero means node good
// - Switch limit in 37.5ms sets bit0 in modes A, E, F
// - Bit0 stays latched until status read
// - Boost limit persisting 30ms sets bit1
// - Buck negative limit sets latched bit2
// - Switch-on done bit only in mode 9
// - Bits 7:6 select spread envelope
// - Bit 5 selects random or linear pattern
// - Bit 4 masks battery removal detection
// - Modes 9 and A run reverse boost
module chb_regs
  import chb_pkg::*;
#(
  parameter int unsigned OSW_WINDOW = OSW_WINDOW_CYC,
  parameter int unsigned BST_PERSIST = BST_PERSIST_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [2:0] thermistor_zone_i,
  input wire logic battery_removed_i,
  input wire logic thermistor_disabled_i,
  input wire logic output_switch_limit_i,
  input wire logic boost_limit_i,
  input wire logic buck_negative_limit_i,
  input wire logic boost_switch_on_done_i,
  output logic [7:0] reg_rdata_o,
  output logic [1:0] spread_envelope_select_o,
  output logic spread_pattern_select_o,
  output logic battery_removal_mask_o,
  output logic [3:0] operating_mode_o,
  output logic reverse_boost_en_o,
  output logic output_switch_en_o
);

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [1:0] env;
    logic pat;
    logic msk;
    logic [3:0] mode;
    logic boost_en;
    logic osw_en;
    logic osw_latch;
    logic buck_latch;
    logic [1:0] swon_sync;
    logic [7:0] rdata;
  } chb_state_t;

  chb_state_t st;
  chb_state_t next_st;

  logic [2:0] zone_s;
  logic removed_s;
  logic therm_off_s;
  logic osw_s;
  logic bst_s;
  logic buck_s;
  logic swon_s;
  logic osw_mode;
  logic osw_event;
  logic osw_window;
  logic bst_persist;
  logic status_rd;
  logic config_wr;
  logic [2:0] zone_code;
  logic [3:0] byp_code;
  logic [7:0] status_val;
  logic [7:0] config_val;

  // Thermistor zone encoding; out-of-range comparator codes report hot,
  // the safe side, so the reserved code never reaches software.
  function automatic logic [2:0] zone_map(input logic [2:0] raw, input logic removed,
                                          input logic masked, input logic off);
    logic [2:0] code;
    code = ZONE_HOT;
    if (off) begin
      code = ZONE_DISABLED;
    end else if (removed && !masked) begin
      code = ZONE_REMOVED;
    end else begin
      unique case (raw)
        ZONE_COLD: code = ZONE_COLD;
        ZONE_COOL: code = ZONE_COOL;
        ZONE_NORMAL: code = ZONE_NORMAL;
        ZONE_WARM: code = ZONE_WARM;
        default: code = ZONE_HOT;
      endcase
    end
    return code;
  endfunction

  // Synchronised copies of the analog event inputs, second stage only.
  assign zone_s = st.sync2[2:0];
  assign removed_s = st.sync2[3];
  assign therm_off_s = st.sync2[4];
  assign osw_s = st.sync2[5];
  assign bst_s = st.sync2[6];
  assign buck_s = st.sync2[7];

  // The switch-on-done flag rides its own two-stage chain in the state struct;
  // only the second stage is read, so a metastable first stage never leaks.
  assign swon_s = st.swon_sync[1];

  // Switch current limit only counts while the output switch is in use.
  assign osw_mode = (st.mode == MODE_BOOST_ON) || (st.mode == MODE_E) ||
                    (st.mode == MODE_F);
  assign osw_event = osw_s && osw_mode;

  // A limit hit keeps the bit visible for the whole window after it.
  chb_span_timer #(
    .CYCLES(OSW_WINDOW),
    .STRETCH(1'b1)
  ) u_osw_window (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .event_i(osw_event),
    .active_o(osw_window)
  );

  // Boost current limit must persist before it is reported.
  chb_span_timer #(
    .CYCLES(BST_PERSIST),
    .STRETCH(1'b0)
  ) u_bst_persist (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .event_i(bst_s),
    .active_o(bst_persist)
  );

  // Access decode on the serial port's register strobes.
  assign status_rd = reg_rd_i && (reg_addr_i == ADDR_STATUS);
  assign config_wr = reg_wr_i && (reg_addr_i == ADDR_CONFIG);

  // Live status value; bypass bits 3:0 all clear means the bypass node is good.
  always_comb begin
    zone_code = zone_map(zone_s, removed_s, st.msk, therm_off_s);
    byp_code = 4'h0;
    byp_code[ST_OSW_BIT] = st.osw_latch || osw_window;
    byp_code[ST_BST_BIT] = bst_persist;
    byp_code[ST_BUCK_BIT] = st.buck_latch;
    byp_code[ST_SWON_BIT] = swon_s && (st.mode == MODE_BOOST_OFF);
    status_val = 8'h00;
    status_val[ST_RSVD_BIT] = 1'b0;
    status_val[ST_ZONE_LSB +: 3] = zone_code;
    status_val[3:0] = byp_code;
    config_val = 8'h00;
    config_val[CF_ENV_LSB +: 2] = st.env;
    config_val[CF_PAT_BIT] = st.pat;
    config_val[CF_MSK_BIT] = st.msk;
    config_val[CF_MODE_LSB +: 4] = st.mode;
  end

  // Next state: synchronisers, configuration, latches and read data.
  always_comb begin
    next_st = st;
    next_st.sync1 = {buck_negative_limit_i, boost_limit_i, output_switch_limit_i,
                     thermistor_disabled_i, battery_removed_i, thermistor_zone_i};
    next_st.sync2 = st.sync1;
    // Switch-on-done gets the same two flip-flops as the other pin inputs.
    next_st.swon_sync = {st.swon_sync[0], boost_switch_on_done_i};
    // Only the configuration register accepts writes; status writes fall away.
    if (config_wr) begin
      next_st.env = reg_wdata_i[CF_ENV_LSB +: 2];
      next_st.pat = reg_wdata_i[CF_PAT_BIT];
      next_st.msk = reg_wdata_i[CF_MSK_BIT];
      next_st.mode = reg_wdata_i[CF_MODE_LSB +: 4];
    end
    // Power stage enables follow the registered mode.
    next_st.boost_en = (st.mode == MODE_BOOST_OFF) || (st.mode == MODE_BOOST_ON);
    next_st.osw_en = (st.mode == MODE_BOOST_ON);
    // A set in the cycle of a read wins, so no event slips past software.
    next_st.osw_latch = (st.osw_latch && !status_rd) || osw_event;
    next_st.buck_latch = (st.buck_latch && !status_rd) || buck_s;
    // Read data is captured before the clear so the read shows the event.
    if (status_rd) begin
      next_st.rdata = status_val;
    end else if (reg_rd_i && (reg_addr_i == ADDR_CONFIG)) begin
      next_st.rdata = config_val;
    end else if (reg_rd_i) begin
      next_st.rdata = READ_NONE;
    end
  end

  // State register with the documented configuration defaults.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.env <= RST_ENV;
      st.pat <= RST_PAT;
      st.msk <= RST_MSK;
      st.mode <= RST_MODE;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a flip-flop of the state.
  assign reg_rdata_o = st.rdata;
  assign spread_envelope_select_o = st.env;
  assign spread_pattern_select_o = st.pat;
  assign battery_removal_mask_o = st.msk;
  assign operating_mode_o = st.mode;
  assign reverse_boost_en_o = st.boost_en;
  assign output_switch_en_o = st.osw_en;

endmodule

`default_nettype wire

// *** chb_pkg.sv ***
package chb_pkg;

  // Clock rate and the two event timings of the bypass node.
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PER_MS_X10 = CLK_HZ / 10_000;
  localparam int OSW_WINDOW_MS_X10 = 375;
  localparam int BST_PERSIST_MS_X10 = 300;
  localparam int OSW_WINDOW_CYC = OSW_WINDOW_MS_X10 * CLK_PER_MS_X10;
  localparam int BST_PERSIST_CYC = BST_PERSIST_MS_X10 * CLK_PER_MS_X10;

  // Register offsets on the serial control port.
  localparam logic [7:0] ADDR_STATUS = 8'h15;
  localparam logic [7:0] ADDR_CONFIG = 8'h16;

  // Status register field positions.
  localparam int ST_RSVD_BIT = 7;
  localparam int ST_ZONE_LSB = 4;
  localparam int ST_OSW_BIT = 0;
  localparam int ST_BST_BIT = 1;
  localparam int ST_BUCK_BIT = 2;
  localparam int ST_SWON_BIT = 3;

  // Configuration register field positions.
  localparam int CF_ENV_LSB = 6;
  localparam int CF_PAT_BIT = 5;
  localparam int CF_MSK_BIT = 4;
  localparam int CF_MODE_LSB = 0;

  // Configuration reset values.
  localparam logic [1:0] RST_ENV = 2'h0;
  localparam logic RST_PAT = 1'b0;
  localparam logic RST_MSK = 1'b0;
  localparam logic [3:0] RST_MODE = 4'h4;

  // Operating modes that matter to the status logic.
  localparam logic [3:0] MODE_BOOST_OFF = 4'h9;
  localparam logic [3:0] MODE_BOOST_ON = 4'hA;
  localparam logic [3:0] MODE_E = 4'hE;
  localparam logic [3:0] MODE_F = 4'hF;

  // Thermistor zone codes.
  localparam logic [2:0] ZONE_COLD = 3'h0;
  localparam logic [2:0] ZONE_COOL = 3'h1;
  localparam logic [2:0] ZONE_NORMAL = 3'h2;
  localparam logic [2:0] ZONE_WARM = 3'h3;
  localparam logic [2:0] ZONE_HOT = 3'h4;
  localparam logic [2:0] ZONE_REMOVED = 3'h5;
  localparam logic [2:0] ZONE_DISABLED = 3'h6;

  localparam int SYNC_W = 8;
  localparam logic [7:0] READ_NONE = 8'h00;

endpackage

// *** chb_span_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

// Stretch mode keeps active_o high for CYCLES cycles after the last event.
// Persist mode raises active_o once the event has been high CYCLES cycles.
module chb_span_timer #(
  parameter int unsigned CYCLES = 16,
  parameter bit STRETCH = 1'b1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic event_i,
  output logic active_o
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] FULL = W'(CYCLES);
  localparam logic [W-1:0] ZERO = '0;
  localparam logic [W-1:0] ONE = W'(1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic active;
  } chb_tmr_t;

  chb_tmr_t st;
  chb_tmr_t next_st;

  // Counter update; persist saturates so a long event cannot wrap it.
  always_comb begin
    next_st = st;
    if (STRETCH) begin
      if (event_i) begin
        next_st.cnt = FULL;
      end else if (st.cnt != ZERO) begin
        next_st.cnt = st.cnt - ONE;
      end
      next_st.active = event_i || (st.cnt > ONE);
    end else begin
      if (!event_i) begin
        next_st.cnt = ZERO;
      end else if (st.cnt != FULL) begin
        next_st.cnt = st.cnt + ONE;
      end
      next_st.active = event_i && (next_st.cnt == FULL);
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign active_o = st.active;

endmodule

`default_nettype wire

// *** chb_regs_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module chb_regs_props
  import chb_pkg::*;
#(
  parameter int unsigned OSW_WINDOW = 20,
  parameter int unsigned BST_PERSIST = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] spread_envelope_select_o,
  input wire logic spread_pattern_select_o,
  input wire logic battery_removal_mask_o,
  input wire logic [3:0] operating_mode_o,
  input wire logic reverse_boost_en_o,
  input wire logic output_switch_en_o
);
  logic st_rd;
  logic [7:0] cfg;
  // Decoded strobes and the packed configuration byte.
  assign st_rd = reg_rd_i && reg_addr_i == ADDR_STATUS;
  assign cfg = {spread_envelope_select_o, spread_pattern_select_o,
    battery_removal_mask_o, operating_mode_o};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_rsvd_bit_zero:
    assert property (st_rd |=> !reg_rdata_o[7]) else $error("status bit 7 set");
  a_zone_code_legal:
    assert property (st_rd |=> reg_rdata_o[6:4] != 3'h7) else $error("zone code 7");
  a_cfg_write_lands:
    assert property (reg_wr_i && reg_addr_i == ADDR_CONFIG |=> cfg == $past(reg_wdata_i))
    else $error("config write lost");
  a_cfg_read_back:
    assert property (reg_rd_i && reg_addr_i == ADDR_CONFIG |=> reg_rdata_o == $past(cfg))
    else $error("config readback wrong");
  a_status_wr_ignored:
    assert property (reg_wr_i && reg_addr_i == ADDR_STATUS |=> $stable(cfg))
    else $error("status write changed config");
  a_boost_mode_decode:
    assert property (reverse_boost_en_o == ($past(operating_mode_o) inside {4'h9, 4'hA}))
    else $error("boost enable wrong");
  a_switch_mode_decode:
    assert property (output_switch_en_o == ($past(operating_mode_o) == MODE_BOOST_ON))
    else $error("switch enable wrong");
  a_swon_mode_only:
    assert property (st_rd ##1 reg_rdata_o[3] |-> $past(operating_mode_o) == MODE_BOOST_OFF)
    else $error("switch-on done outside mode 9");
  a_rdata_holds_idle:
    assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  // Main scenarios reached.
  cover property (st_rd ##1 reg_rdata_o[0]);
  cover property (st_rd ##1 reg_rdata_o[1]);
  cover property (st_rd ##1 reg_rdata_o[2]);
  cover property (st_rd ##1 reg_rdata_o[3]);
endmodule
bind chb_regs chb_regs_props #(.OSW_WINDOW(OSW_WINDOW), .BST_PERSIST(BST_PERSIST)) i_chb_regs_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .spread_envelope_select_o(spread_envelope_select_o),
  .spread_pattern_select_o(spread_pattern_select_o),
  .battery_removal_mask_o(battery_removal_mask_o), .operating_mode_o(operating_mode_o),
  .reverse_boost_en_o(reverse_boost_en_o), .output_switch_en_o(output_switch_en_o));
`default_nettype wire

// *** chb_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module chb_host (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // Idle bus at time zero.
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Released lines show the inverse so a stale value is never mistaken for a hold.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= v;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~v;
  endtask
  // Read data is registered at the strobe edge, so it is taken just after it.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    v = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import chb_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] zone = 3'h2;
  logic rem = 1'b0, dis = 1'b0, done = 1'b0;
  logic [2:0] ev = 3'h0;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr, rd, pat, msk, rb, swe;
  wire logic [1:0] env;
  wire logic [3:0] mode;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] d, v;
  // Zone rows: raw zone, removed, disabled, mask, expected code.
  logic [8:0] rows [9] = '{{3'h0, 3'b000, 3'h0}, {3'h1, 3'b000, 3'h1}, {3'h2, 3'b000, 3'h2},
    {3'h3, 3'b000, 3'h3}, {3'h4, 3'b000, 3'h4}, {3'h7, 3'b000, 3'h4}, {3'h2, 3'b100, 3'h5},
    {3'h2, 3'b101, 3'h2}, {3'h3, 3'b110, 3'h6}};
  always #50 clk_i = ~clk_i;
  chb_host i_chb_host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
  chb_regs #(.OSW_WINDOW(20), .BST_PERSIST(16)) i_chb_regs (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .thermistor_zone_i(zone), .battery_removed_i(rem),
    .thermistor_disabled_i(dis), .output_switch_limit_i(ev[0]), .boost_limit_i(ev[1]),
    .buck_negative_limit_i(ev[2]), .boost_switch_on_done_i(done), .reg_rdata_o(rdata),
    .spread_envelope_select_o(env), .spread_pattern_select_o(pat),
    .battery_removal_mask_o(msk), .operating_mode_o(mode), .reverse_boost_en_o(rb),
    .output_switch_en_o(swe));
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t ns: %s", $time, m);
    end
  endtask
  // Status reads keep the zone at normal, so only the bypass nibble varies.
  task st(input logic [3:0] bypass_node);
    i_chb_host.rd_reg(ADDR_STATUS, d);
    chk(d, {4'h2, bypass_node}, "status byte");
  endtask
  // Held three cycles so the two-stage synchroniser always catches it.
  task pulse(input logic [2:0] m);
    @(posedge clk_i);
    ev <= m;
    repeat (3) @(posedge clk_i);
    ev <= 3'h0;
    repeat (30) @(posedge clk_i);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The run needs about 450 cycles; the ceiling leaves ample margin.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({env, pat, msk, mode}, 8'h04, "config reset");
    chk({6'h0, rb, swe}, 8'h00, "enables reset");
    foreach (rows[i]) begin
      @(posedge clk_i);
      {zone, rem, dis} <= rows[i][8:4];
      i_chb_host.wr_reg(ADDR_CONFIG, {3'h0, rows[i][3], 4'h4});
      repeat (5) @(posedge clk_i);
      i_chb_host.rd_reg(ADDR_STATUS, d);
      chk(d, {1'b0, rows[i][2:0], 4'h0}, "zone row");
    end
    @(posedge clk_i);
    {zone, rem, dis} <= 5'b01000;
    $display("zone rows done");
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], ~i[0], i[1], 4'h4};
      i_chb_host.wr_reg(ADDR_CONFIG, v);
      @(posedge clk_i);
      #1;
      chk({env, pat, msk, mode}, v, "config fields");
      i_chb_host.rd_reg(ADDR_CONFIG, d);
      chk(d, v, "config readback");
    end
    i_chb_host.wr_reg(ADDR_STATUS, 8'hFF);
    i_chb_host.rd_reg(ADDR_CONFIG, d);
    chk(d, v, "status write leaked");
    st(4'h0);
    i_chb_host.rd_reg(8'h20, d);
    chk(d, READ_NONE, "unmapped read");
    $display("config done");
    i_chb_host.wr_reg(ADDR_CONFIG, 8'h0A);
    repeat (2) @(posedge clk_i);
    #1;
    chk({6'h0, rb, swe}, 8'h03, "mode A enables");
    pulse(3'b001);
    st(4'h1);
    st(4'h0);
    // The switch limit also counts in the two other modes that use the switch.
    for (int j = 0; j < 2; j++) begin
      i_chb_host.wr_reg(ADDR_CONFIG, (j == 0) ? 8'h0E : 8'h0F);
      pulse(3'b001);
      st(4'h1);
      st(4'h0);
    end
    // A hit present during the read keeps the latch set after the window ends.
    @(posedge clk_i);
    ev <= 3'b001;
    repeat (4) @(posedge clk_i);
    st(4'h1);
    st(4'h1);
    @(posedge clk_i);
    ev <= 3'h0;
    repeat (30) @(posedge clk_i);
    st(4'h1);
    st(4'h0);
    i_chb_host.wr_reg(ADDR_CONFIG, 8'h04);
    pulse(3'b001);
    st(4'h0);
    pulse(3'b100);
    st(4'h4);
    st(4'h0);
    @(posedge clk_i);
    ev <= 3'b010;
    repeat (10) @(posedge clk_i);
    st(4'h0);
    repeat (20) @(posedge clk_i);
    st(4'h2);
    @(posedge clk_i);
    ev <= 3'h0;
    repeat (5) @(posedge clk_i);
    st(4'h0);
    i_chb_host.wr_reg(ADDR_CONFIG, 8'h09);
    done <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    chk({6'h0, rb, swe}, 8'h02, "mode 9 enables");
    st(4'h8);
    i_chb_host.wr_reg(ADDR_CONFIG, 8'h04);
    repeat (2) @(posedge clk_i);
    st(4'h0);
    $display("bypass done");
    // A reset in mid-run must bring every configuration field back to its default.
    i_chb_host.wr_reg(ADDR_CONFIG, 8'hE9);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({env, pat, msk, mode}, 8'h04, "config mid reset");
    chk({6'h0, rb, swe}, 8'h00, "enables mid reset");
    st(4'h0);
    $display("reset done");
    final_report();
  end
endmodule
`default_nettype wire
